// >>> inc/cie_regs.svh
// constants for the instruction subset executor: opcodes, vectors, stack depth
// assumes inclusion by bare name from the core module
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH
// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define CIE_OP_CALL_PFX 2'h2
`define CIE_OP_SKIP_PFX 4'h7
`define CIE_OP_ZFILE_PFX 7'h03
`define CIE_OP_ZACC 14'h0103
`define CIE_OP_RET 14'h0008
`define CIE_OP_IRET 14'h0009
`define CIE_OP_RRC_PFX 6'h0c
// ----------------------------------------
// program counter values and stack depth
// ----------------------------------------
`define CIE_IRQ_VECTOR 13'h0004
`define CIE_PC_RESET 13'h0000
`define CIE_STACK_DEPTH 8
`endif

// >>> inc/cie_pkg.sv
// types shared by the instruction subset executor
// assumes the constants header is on the include path
package cie_pkg;
  // status flags touched by this subset
  typedef struct packed
  {
    logic result_nil_flag;
    logic rollover_bit;
  } cie_flags_s;
  // file register write request
  typedef struct packed
  {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } cie_fwr_s;
  // execution phase
  typedef enum logic [0:0]
  {
    CIE_EXEC = 1'b0,
    CIE_FLUSH = 1'b1
  } cie_state_e;
endpackage

// >>> verilog/cie_core.sv
// executes a subset of an 8-bit core: skip, call, return, clears, rotate, irq entry
// assumes instructions arrive prefetched and file reads are combinational
// Function
// - interrupt saves only the return pc
// - skip_if_bit_high tests bit b of file
// - taken skip flushes prefetch, two cycles
// - call pushes pc plus one first
// - call loads literal and pc_upper_holding bits
// - call decoded by prefix, two cycles
// - zero_file_reg clears file, sets nil flag
// - return pops stack into pc, two cycles
// - rotate right through rollover_bit only
// - destination bit selects accumulator or file
// - irq clears enable, pushes, vectors 0004h
// - interrupt_return_op pops and sets enable
`timescale 1ns/1ns
`include "cie_regs.svh"
module cie_core
  import cie_pkg::*;
#(
  parameter int DEPTH = `CIE_STACK_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // instruction stream
  input wire logic [13:0] instr,
  input wire logic irq_req,
  // file register access
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_raddr,
  output cie_fwr_s file_wr,
  input wire logic [7:0] pc_upper_holding,
  // visible core state
  output logic [12:0] pc,
  output logic [7:0] accumulator,
  output cie_flags_s flags,
  output logic master_irq_enable,
  output logic flush
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  cie_state_e state, next_state; // flush phase after a redirect
  logic [12:0] stack [DEPTH]; // return addresses, circular like the real core
  logic [$clog2(DEPTH)-1:0] sp, next_sp; // next free slot
  logic [12:0] next_pc;
  logic [7:0] next_acc;
  cie_flags_s next_flags;
  logic next_gie;
  logic push;
  logic [12:0] push_val;
  logic [12:0] stack_head; // top of stack
  logic [$clog2(DEPTH)-1:0] sp_dec;
  logic [7:0] rot;
  logic take_irq;

  assign sp_dec = sp - 1'b1;
  assign stack_head = stack[sp_dec];
  assign file_raddr = instr[6:0];
  assign flush = (state == CIE_FLUSH);
  assign rot = {flags.rollover_bit, file_rdata[7:1]};
  // irq is only taken at an instruction boundary, never mid-flush
  assign take_irq = irq_req && master_irq_enable && (state == CIE_EXEC);

  // ----------------------------------------
  // next-value logic
  // ----------------------------------------
  always_comb
  begin
    next_state = CIE_EXEC;
    next_pc = pc + 13'h0001;
    next_acc = accumulator;
    next_flags = flags;
    next_gie = master_irq_enable;
    next_sp = sp;
    push = 1'b0;
    push_val = pc + 13'h0001;
    file_wr = '0;
    if (state == CIE_FLUSH)
    begin
      // prefetched word discarded, nop cycle
      next_pc = pc;
    end
    else if (take_irq)
    begin
      // only the return pc is saved; w and status left to software
      push = 1'b1;
      push_val = pc;
      next_gie = 1'b0;
      next_pc = `CIE_IRQ_VECTOR;
      next_state = CIE_FLUSH;
    end
    else if (instr[13:12] == `CIE_OP_CALL_PFX && !instr[11])
    begin
      // call: push pc+1, then jump
      push = 1'b1;
      next_pc = {pc_upper_holding[4:3], instr[10:0]};
      next_state = CIE_FLUSH;
    end
    else if (instr[13:10] == `CIE_OP_SKIP_PFX)
    begin
      // skip when tested bit is one; flags untouched
      if (file_rdata[instr[9:7]])
      begin
        // step over the discarded word so execution resumes two words on
        next_pc = pc + 13'h0002;
        next_state = CIE_FLUSH;
      end
    end
    else if (instr[13:7] == `CIE_OP_ZFILE_PFX)
    begin
      file_wr = '{en: 1'b1, addr: instr[6:0], data: 8'h00};
      next_flags.result_nil_flag = 1'b1;
    end
    else if (instr == `CIE_OP_ZACC)
    begin
      next_acc = 8'h00;
      next_flags.result_nil_flag = 1'b1;
    end
    else if (instr == `CIE_OP_RET || instr == `CIE_OP_IRET)
    begin
      next_sp = sp_dec;
      next_pc = stack_head;
      next_state = CIE_FLUSH;
      if (instr == `CIE_OP_IRET)
        next_gie = 1'b1;
    end
    else if (instr[13:8] == `CIE_OP_RRC_PFX)
    begin
      next_flags.rollover_bit = file_rdata[0];
      if (instr[7])
        file_wr = '{en: 1'b1, addr: instr[6:0], data: rot};
      else
        next_acc = rot;
    end
    if (push)
      next_sp = sp + 1'b1;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= CIE_EXEC;
      pc <= `CIE_PC_RESET;
      accumulator <= 8'h00;
      flags <= '0;
      master_irq_enable <= 1'b0;
      sp <= '0;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      accumulator <= next_acc;
      flags <= next_flags;
      master_irq_enable <= next_gie;
      sp <= next_sp;
    end
  end

  // stack storage, no reset needed; contents undefined until pushed
  always_ff @(posedge clk)
  begin
    if (push)
      stack[sp] <= push_val;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_irq_vector: assert property (@(posedge clk) disable iff (!reset_n)
    take_irq |=> pc == `CIE_IRQ_VECTOR && !master_irq_enable && flush)
    else $error("irq entry did not vector");
  a_irq_keeps_acc: assert property (@(posedge clk) disable iff (!reset_n)
    take_irq |=> $stable(accumulator) && $stable(flags))
    else $error("irq entry changed w or flags");
  a_call_target: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:11] == 3'b100) |=>
    pc == {$past(pc_upper_holding[4:3]), $past(instr[10:0])} ##1 pc == $past(pc))
    else $error("call target or flush wrong");
  a_call_push: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:11] == 3'b100) |=> stack_head == $past(pc) + 13'h0001)
    else $error("call pushed wrong address");
  a_skip_taken: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:10] == 4'h7 && file_rdata[instr[9:7]]) |=>
    flush && $stable(flags) && pc == $past(pc) + 13'h0002)
    else $error("taken skip did not flush");
  a_zero_file: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:7] == 7'h03) |->
    file_wr.en && file_wr.data == 8'h00 ##1 flags.result_nil_flag)
    else $error("file clear wrong");
  a_rotate_carry: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:8] == 6'h0c) |=>
    flags.rollover_bit == $past(file_rdata[0]) &&
    flags.result_nil_flag == $past(flags.result_nil_flag))
    else $error("rotate carry wrong");
  a_rotate_dest: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:7] == 7'h18) |=>
    accumulator == {$past(flags.rollover_bit), $past(file_rdata[7:1])})
    else $error("rotate into w wrong");
  a_iret_enable: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr == 14'h0009) |=> master_irq_enable && flush)
    else $error("return from irq did not enable");
  // a discarded word may neither write a file register nor move the pc
  a_flush_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    flush |-> !file_wr.en ##1 !flush && pc == $past(pc))
    else $error("flush cycle was not a no-operation");
  // plain return lands on the popped address and enters the flush phase
  a_ret_pop: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr == `CIE_OP_RET) |=> pc == $past(stack_head) && flush)
    else $error("return did not pop the stack");
  // irq entry stacks the address of the instruction it pre-empted
  a_irq_push: assert property (@(posedge clk) disable iff (!reset_n)
    take_irq |=> stack_head == $past(pc))
    else $error("irq entry pushed wrong address");
  // accumulator clear touches no file register and keeps the rollover bit
  a_zero_acc: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr == `CIE_OP_ZACC) |->
    !file_wr.en ##1 accumulator == 8'h00 && flags.result_nil_flag && $stable(flags.rollover_bit))
    else $error("accumulator clear wrong");
  // call changes neither flags nor accumulator
  a_call_flags: assert property (@(posedge clk) disable iff (!reset_n)
    (!flush && !take_irq && instr[13:11] == 3'b100) |=> $stable(flags) && $stable(accumulator))
    else $error("call changed flags or accumulator");
endmodule

// >>> verif/cpu_instr_subset_exec_test.sv
// self-checking bench for the instruction subset executor
// assumes cie_pkg is compiled first; the bench acts as file memory
`timescale 1ns/1ns
module cpu_instr_subset_exec_test
  import cie_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic irq_req = 1'b0;
  logic [7:0] fval = 8'h00; // read data of the addressed file register
  logic [7:0] hold = 8'h18; // pc upper holding, bits 4:3 set
  logic [6:0] file_raddr;
  cie_fwr_s file_wr;
  logic [12:0] pc;
  logic [7:0] accumulator;
  cie_flags_s flags;
  logic master_irq_enable;
  logic flush;
  int miscompares = 0;
  int samples_checked = 0;
  logic [12:0] p;
  always #5 clk = ~clk;
  cie_core #(.DEPTH(8)) dut (.clk(clk), .reset_n(reset_n), .instr(instr), .irq_req(irq_req),
    .file_rdata(fval), .file_raddr(file_raddr), .file_wr(file_wr),
    .pc_upper_holding(hold), .pc(pc), .accumulator(accumulator), .flags(flags),
    .master_irq_enable(master_irq_enable), .flush(flush));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // present a word at the falling edge; the previous word executes in between
  // the short pause lets combinational outputs settle before the caller looks
  task run(input logic [13:0] w);
    @(negedge clk);
    instr = w;
    #1;
  endtask
  // same, with new file read data driven at the same falling edge
  task run_f(input logic [13:0] w, input logic [7:0] f);
    @(negedge clk);
    instr = w;
    fval = f;
    #1;
  endtask
  // mid-run reset: visible state returns to idle, first word runs at first edge
  task do_reset;
    @(negedge clk);
    reset_n = 1'b0;
    instr = 14'h0000;
    #1;
    chk("rpc2", {pc, master_irq_enable, flush}, 15'h0000);
    chk("racc", {accumulator, flags}, 10'h000);
    @(negedge clk);
    reset_n = 1'b1;
    run(14'h0000);
    chk("rfirst", pc, 13'h0001);
  endtask
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", n, exp, seen);
      miscompares++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_skip;
    run_f({4'h7, 3'd2, 7'h10}, 8'h04);
    p = pc;
    chk("raddr", file_raddr, 7'h10);
    run(14'h0000);
    chk("flush", flush, 1'b1);
    chk("pc", pc, p + 13'h0002);
    chk("flags", flags, 2'h0);
    run(14'h0000);
    chk("flush2", flush, 1'b0);
    chk("pc2", pc, p + 13'h0002);
    run_f({4'h7, 3'd2, 7'h10}, 8'hfb); // tested bit clear, no skip
    run(14'h0000);
    chk("noskip", flush, 1'b0);
    $display("skip test done");
  endtask
  task t_call;
    run({3'b100, 11'h555});
    p = pc;
    run(14'h0000);
    chk("target", pc, {2'b11, 11'h555});
    chk("flush", flush, 1'b1);
    run(14'h0000);
    chk("hold", pc, {2'b11, 11'h555});
    chk("flags", flags, 2'h0);
    run(14'h0008);
    run(14'h0000);
    chk("return", pc, p + 13'h0001);
    chk("rflush", flush, 1'b1);
    run(14'h0000);
    $display("call test done");
  endtask
  task t_data;
    run_f({6'h0c, 1'b1, 7'h22}, 8'ha5);
    chk("wr", {file_wr.en, file_wr.data}, 9'h152);
    run(14'h0000);
    chk("carry", flags, 2'h1);
    run_f({6'h0c, 1'b0, 7'h22}, 8'h02);
    chk("wen", file_wr.en, 1'b0);
    run(14'h0000);
    chk("acc", accumulator, 8'h81);
    chk("carry2", flags, 2'h0);
    run_f({7'h03, 7'h21}, 8'h5a);
    chk("zf", file_wr, {1'b1, 7'h21, 8'h00});
    run(14'h0000);
    chk("zflag", {accumulator, flags}, 10'h206);
    // only reset clears the nil flag, so the accumulator clear starts from reset
    do_reset();
    run_f({6'h0c, 1'b0, 7'h22}, 8'h03);
    run(14'h0103);
    chk("acc2", {accumulator, flags}, 10'h005);
    chk("zwen", file_wr.en, 1'b0);
    run(14'h0000);
    chk("zacc", {accumulator, flags}, 10'h003);
    $display("data test done");
  endtask
  task t_irq;
    run({3'b100, 11'h100});
    p = pc;
    run(14'h0000);
    run(14'h0009);
    run(14'h0000);
    chk("ien", master_irq_enable, 1'b1);
    chk("ipc", pc, p + 13'h0001);
    @(negedge clk);
    irq_req = 1'b1; // taken at the next edge, word at p not executed
    #1;
    p = pc;
    @(negedge clk);
    irq_req = 1'b0;
    #1;
    chk("vec", pc, 13'h0004);
    chk("iden", master_irq_enable, 1'b0);
    chk("ctx", {accumulator, flags}, 10'h003);
    run(14'h0000);
    run(14'h0008);
    run(14'h0000);
    chk("back", pc, p);
    $display("irq test done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(negedge clk);
    chk("rpc", {pc, master_irq_enable}, 14'h0000);
    reset_n = 1'b1;
    t_skip();
    t_call();
    t_data();
    t_irq();
    end_sim();
  end
  // guard against a hung run
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule
